// ### rtl/g0_eoi_consts.vh
`ifndef G0_EOI_CONSTS_VH
`define G0_EOI_CONSTS_VH

// =====================================================================
// Field layout of the completion write
`define ID_LSB             0
`define ID_MSB             23
`define ID_WIDE_MASK       24'hffffff
`define ID_NARROW_MASK     24'h00ffff

// =====================================================================
// Identifier width codes reported to software
`define IDW_CODE_16        3'h0
`define IDW_CODE_24        3'h1

// =====================================================================
// Special identifiers (inclusive range) that a completion write ignores
`define SPECIAL_ID_FIRST   24'h0003fc
`define SPECIAL_ID_LAST    24'h0003ff

// =====================================================================
// Exception level encoding of the writer
`define LVL_EL0            2'h0
`define LVL_EL1            2'h1
`define LVL_EL2            2'h2
`define LVL_EL3            2'h3

// =====================================================================
// Target register of a write
`define TGT_COMPLETION     1'b0
`define TGT_DEACTIVATE     1'b1

// =====================================================================
// One-hot outcome codes, plus the all-zero OUT_NONE
`define OUT_NONE           5'h00
`define OUT_ACCEPT         5'h01
`define OUT_UNDEF          5'h02
`define OUT_TRAP_EL2       5'h04
`define OUT_TRAP_EL3       5'h08
`define OUT_VIRTUAL        5'h10

// =====================================================================
// Reset values
`define RST_ID             24'h000000
`define RST_OUT            5'h00

`endif

// ### rtl/group0_eoi_access_checker.v
`timescale 1ns/1ns
`include "g0_eoi_consts.vh"

module group0_eoi_access_checker
#(
   parameter ID_BITS = 24
)
(
   input  wire        sys_clk_i,
   input  wire        srst_i,
   input  wire        ce_i,
   // Write request from the core
   input  wire        wr_valid_i,
   input  wire        wr_target_i,
   input  wire [31:0] wr_data_i,
   input  wire [1:0]  wr_level_i,
   input  wire        wr_secure_i,
   input  wire        wr_monitor_mode_i,
   // Implementation options
   input  wire        el2_present_i,
   input  wire        el2_is_64_i,
   input  wire        el3_present_i,
   input  wire        el3_is_64_i,
   // Split-deactivation bits
   input  wire        split_deactivation_bit_ctlr_i,
   input  wire        split_deactivation_bit_el3_i,
   input  wire        split_deactivation_bit_el1s_i,
   input  wire        split_deactivation_bit_el1ns_i,
   // Enables, routing and trap controls
   input  wire        el1_sysreg_enable_i,
   input  wire        el2_sysreg_enable_i,
   input  wire        el3_sysreg_enable_i,
   input  wire        fast_irq_route_override_i,
   input  wire        normal_irq_route_override_i,
   input  wire        trap_general_bit_i,
   input  wire        group_twelve_trap_bit_i,
   input  wire        trap_all_group0_bit_i,
   input  wire        trap_common_regs_bit_i,
   input  wire        fast_interrupt_route_bit_i,
   // Outcome
   output reg         resp_valid_o,
   output reg  [4:0]  resp_code_o,
   output reg         prio_drop_o,
   output reg         deactivate_o,
   output reg         virt_write_o,
   output reg  [23:0] interrupt_identifier_o,
   output wire [2:0]  identifier_width_field_o
);

   // ==================================================================
   // Identifier decode
   // ==================================================================
   localparam [23:0] ID_MASK = (ID_BITS == 16) ? `ID_NARROW_MASK : `ID_WIDE_MASK;

   assign identifier_width_field_o = (ID_BITS == 16) ? `IDW_CODE_16 : `IDW_CODE_24;

   function is_special;
      input [23:0] id;
      begin
         is_special = (id >= `SPECIAL_ID_FIRST) && (id <= `SPECIAL_ID_LAST);
      end
   endfunction

   wire [23:0] id_field;
   wire        id_special;

   assign id_field   = wr_data_i[`ID_MSB:`ID_LSB] & ID_MASK;
   assign id_special = is_special(id_field);

   // ==================================================================
   // Split-deactivation selection
   // ==================================================================
   reg split_bit;

   always @*
   begin
      if (!el3_present_i)
         split_bit = split_deactivation_bit_ctlr_i;
      else if (wr_monitor_mode_i)
         split_bit = split_deactivation_bit_el3_i;
      else if (wr_secure_i)
         split_bit = split_deactivation_bit_el1s_i;
      else
         split_bit = split_deactivation_bit_el1ns_i;
   end

   // ==================================================================
   // Access checks
   // ==================================================================
   // Writer level compare, shared by every level decode below
   function level_is;
      input [1:0] lvl;
      input [1:0] want;
      begin
         level_is = (lvl == want);
      end
   endfunction

   wire at_el0;
   wire at_el1;
   wire at_el2;
   wire at_el3;
   wire ns_el1;
   wire el3_32;
   wire el3_64;
   wire hyp_override;
   wire undef_enable;
   wire undef_en_el1;
   wire undef_en_el2;
   wire undef_en_el3;
   wire undef_route32;
   wire undef_r32_el2;
   wire undef_r32_el3;
   wire undef_r32_ns;
   wire undef_tge;
   wire trap2;
   wire trap2_group;
   wire trap2_all0;
   wire trap2_common;
   wire trap3;
   wire trap3_sec;
   wire trap3_el2;
   wire trap3_ns;
   wire to_virtual;
   wire is_compl;
   wire is_deact;

   assign at_el0 = level_is(wr_level_i, `LVL_EL0);
   assign at_el1 = level_is(wr_level_i, `LVL_EL1);
   assign at_el2 = level_is(wr_level_i, `LVL_EL2);
   assign at_el3 = level_is(wr_level_i, `LVL_EL3);
   assign ns_el1 = at_el1 && !wr_secure_i;
   assign el3_32 = el3_present_i && !el3_is_64_i;
   assign el3_64 = el3_present_i && el3_is_64_i;
   assign is_compl = (wr_target_i == `TGT_COMPLETION);
   assign is_deact = (wr_target_i == `TGT_DEACTIVATE);

   // The deactivate encoding redirects on either override, the completion one on fast only
   assign hyp_override = (wr_target_i == `TGT_DEACTIVATE) ?
                         (fast_irq_route_override_i || normal_irq_route_override_i) :
                         fast_irq_route_override_i;

   assign undef_en_el1 = at_el1 && !el1_sysreg_enable_i;

   assign undef_en_el2 = at_el2 && !el2_sysreg_enable_i;

   assign undef_en_el3 = at_el3 && !el3_sysreg_enable_i;

   // EL0 has no access to this register at all
   assign undef_enable = undef_en_el1 || undef_en_el2 || undef_en_el3 || at_el0;

   assign undef_r32_el2 = at_el2;

   assign undef_r32_el3 = at_el3 && !wr_monitor_mode_i;

   assign undef_r32_ns = ns_el1 && !fast_irq_route_override_i;

   assign undef_route32 = el3_32 && fast_interrupt_route_bit_i &&
                          (undef_r32_el2 || undef_r32_el3 || undef_r32_ns);

   assign undef_tge = ns_el1 && trap_general_bit_i;

   // group trap to EL2
   // Hyp mode of a 32-bit hypervisor is the same EL2 outcome, so the
   // hypervisor's execution state is deliberately not looked at.
   assign trap2_group = el2_present_i && group_twelve_trap_bit_i;

   assign trap2_all0 = is_compl && trap_all_group0_bit_i;

   assign trap2_common = is_deact && trap_common_regs_bit_i;

   // Trap-general already makes these writes undefined
   assign trap2 = ns_el1 && !trap_general_bit_i &&
                  (trap2_group || trap2_all0 || trap2_common);

   assign trap3_sec = at_el1 && wr_secure_i;

   assign trap3_el2 = at_el2;

   // Non-secure EL1 to EL3, only while the fast override is clear
   assign trap3_ns = ns_el1 && !fast_irq_route_override_i;

   // All three need 64-bit EL3 and the route bit
   assign trap3 = el3_64 && fast_interrupt_route_bit_i &&
                  (trap3_sec || trap3_el2 || trap3_ns);

   // override sends Non-secure EL1 to the virtual copy
   assign to_virtual = ns_el1 && hyp_override;

   // Undefined outranks traps; EL2 traps outrank the virtual redirect, which in turn
   // outranks EL3 traps (both fire together on a deactivate write with only the normal override set).
   reg [4:0] outcome;

   always @*
   begin
      if (undef_enable || undef_route32 || undef_tge)
         outcome = `OUT_UNDEF;
      else if (trap2)
         outcome = `OUT_TRAP_EL2;
      else if (to_virtual)
         outcome = `OUT_VIRTUAL;
      else if (trap3)
         outcome = `OUT_TRAP_EL3;
      else
         outcome = `OUT_ACCEPT;
   end

   // ==================================================================
   // Effects of an accepted write
   // ==================================================================
   reg next_drop;
   reg next_deact;

   always @*
   begin
      next_drop  = 1'b0;
      next_deact = 1'b0;
      if ((outcome == `OUT_ACCEPT) && !id_special)
      begin
         if (wr_target_i == `TGT_COMPLETION)
         begin
            next_drop  = 1'b1;
            next_deact = !split_bit;
         end
         else
         begin
            // deactivate register works only when split; else ignored
            next_deact = split_bit;
         end
      end
   end

   // ==================================================================
   // Registered outcome
   // ==================================================================
   // No check that the identifier matches the last acknowledge: a mismatch
   // is the writer's fault and is passed on unchanged.
   always @(posedge sys_clk_i)
   begin
      // Reset waits for the enable too, so a frozen block keeps all its state
      if (ce_i)
      begin
         if (srst_i)
         begin
            resp_valid_o           <= 1'b0;
            resp_code_o            <= `RST_OUT;
            prio_drop_o            <= 1'b0;
            deactivate_o           <= 1'b0;
            virt_write_o           <= 1'b0;
            interrupt_identifier_o <= `RST_ID;
         end
         else
         begin
            resp_valid_o <= wr_valid_i;
            resp_code_o  <= wr_valid_i ? outcome : `OUT_NONE;
            prio_drop_o  <= wr_valid_i && next_drop;
            deactivate_o <= wr_valid_i && next_deact;
            virt_write_o <= wr_valid_i && (outcome == `OUT_VIRTUAL);
            if (wr_valid_i)
               interrupt_identifier_o <= id_field;
         end
      end
   end

endmodule

// ### verification/core_write_model.sv
`timescale 1ns/1ns
// =====================================================================
// Core side: one register write per call
module core_write_model
(
   input  wire         sys_clk_i,
   output logic        wr_valid_o,
   output logic        wr_target_o,
   output logic [31:0] wr_data_o,
   output logic [1:0]  wr_level_o,
   output logic        wr_secure_o,
   output logic        wr_monitor_mode_o
);
   initial
   begin
      {wr_valid_o, wr_target_o, wr_data_o, wr_level_o, wr_secure_o, wr_monitor_mode_o} = '0;
   end
   // Caller passes the acknowledged id, deactivate after drop
   task write(input logic [4:0] m, input logic [31:0] d);
      begin
         @(negedge sys_clk_i);
         {wr_valid_o, wr_target_o, wr_level_o, wr_secure_o, wr_monitor_mode_o} = {1'b1, m};
         wr_data_o = d;
         @(negedge sys_clk_i);
         wr_valid_o = 1'b0;
         // Idle data is inverted so a stale word never looks current
         wr_data_o = ~wr_data_o;
      end
   endtask
endmodule

// ### verification/g0_eoi_checker_assertions.sv
`timescale 1ns/1ns
`include "g0_eoi_consts.vh"
module g0_eoi_checker
#(
   parameter ID_BITS = 24
)
(
   input wire        sys_clk_i,
   input wire        srst_i,
   input wire        ce_i,
   input wire        wr_valid_i,
   input wire        wr_target_i,
   input wire [31:0] wr_data_i,
   input wire [1:0]  wr_level_i,
   input wire        wr_secure_i,
   input wire        el1_sysreg_enable_i,
   input wire        el2_sysreg_enable_i,
   input wire        el3_sysreg_enable_i,
   input wire        resp_valid_o,
   input wire [4:0]  resp_code_o,
   input wire        prio_drop_o,
   input wire        deactivate_o,
   input wire        virt_write_o,
   input wire [23:0] interrupt_identifier_o
);
   localparam logic [23:0] MASK = (ID_BITS == 16) ? `ID_NARROW_MASK : `ID_WIDE_MASK;
   wire [23:0] id_in = wr_data_i[23:0] & MASK;
   wire        off = (wr_level_i == `LVL_EL1 && !el1_sysreg_enable_i) ||
                     (wr_level_i == `LVL_EL2 && !el2_sysreg_enable_i) ||
                     (wr_level_i == `LVL_EL3 && !el3_sysreg_enable_i);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (srst_i);
   sequence s_taken;
      wr_valid_i && ce_i;
   endsequence
   chk_resp_next: assert property (s_taken |=> resp_valid_o && $onehot(resp_code_o))
      else $error("missing response");
   chk_idle_quiet: assert property (!wr_valid_i && ce_i |=> !resp_valid_o && !prio_drop_o
      && !deactivate_o && resp_code_o == `OUT_NONE) else $error("spurious pulse");
   chk_id_masked: assert property (s_taken |=> interrupt_identifier_o == $past(id_in))
      else $error("identifier not masked");
   chk_undef_enable: assert property (s_taken ##0 off |=> resp_code_o == `OUT_UNDEF)
      else $error("disabled write not undefined");
   chk_special_ignored: assert property (s_taken ##0 (wr_target_i == `TGT_COMPLETION
      && id_in >= `SPECIAL_ID_FIRST && id_in <= `SPECIAL_ID_LAST) |=> !prio_drop_o && !deactivate_o)
      else $error("special id acted on");
   chk_drop_accept: assert property (prio_drop_o |-> resp_code_o == `OUT_ACCEPT
      && $past(wr_target_i) == `TGT_COMPLETION) else $error("drop without accepted completion");
   chk_deact_alone: assert property (deactivate_o && !prio_drop_o |->
      $past(wr_target_i) == `TGT_DEACTIVATE) else $error("lone deactivate from completion");
   chk_virtual_pair: assert property (virt_write_o |-> resp_code_o == `OUT_VIRTUAL &&
      $past(wr_level_i) == `LVL_EL1 && !$past(wr_secure_i)) else $error("bad virtual forward");
endmodule
bind group0_eoi_access_checker g0_eoi_checker #(.ID_BITS(ID_BITS)) i_g0_eoi_checker (
   .sys_clk_i(sys_clk_i),
   .srst_i(srst_i),
   .ce_i(ce_i),
   .wr_valid_i(wr_valid_i),
   .wr_target_i(wr_target_i),
   .wr_data_i(wr_data_i),
   .wr_level_i(wr_level_i),
   .wr_secure_i(wr_secure_i),
   .el1_sysreg_enable_i(el1_sysreg_enable_i),
   .el2_sysreg_enable_i(el2_sysreg_enable_i),
   .el3_sysreg_enable_i(el3_sysreg_enable_i),
   .resp_valid_o(resp_valid_o),
   .resp_code_o(resp_code_o),
   .prio_drop_o(prio_drop_o),
   .deactivate_o(deactivate_o),
   .virt_write_o(virt_write_o),
   .interrupt_identifier_o(interrupt_identifier_o)
);

// ### verification/group0_eoi_access_checker_tb.sv
`timescale 1ns/1ns
`include "g0_eoi_consts.vh"
module group0_eoi_access_checker_tb;
   logic        sys_clk_i;
   logic        srst_i;
   logic [17:0] cfg;
   logic        ce;
   int          error_cnt;
   int          samples_checked;
   wire         v, tg, sec, mon, rv, pd, da, vw;
   wire [31:0]  d;
   wire [1:0]   lv;
   wire [4:0]   rc;
   wire [23:0]  ident;
   wire [2:0]   idw;
   core_write_model i_core_write_model (.sys_clk_i(sys_clk_i), .wr_valid_o(v),
      .wr_target_o(tg), .wr_data_o(d), .wr_level_o(lv), .wr_secure_o(sec), .wr_monitor_mode_o(mon));
   group0_eoi_access_checker #(.ID_BITS(24)) i_group0_eoi_access_checker (.sys_clk_i(sys_clk_i),
      .srst_i(srst_i), .ce_i(ce), .wr_valid_i(v), .wr_target_i(tg), .wr_data_i(d),
      .wr_level_i(lv), .wr_secure_i(sec), .wr_monitor_mode_i(mon), .el2_present_i(cfg[17]),
      .el2_is_64_i(cfg[16]), .el3_present_i(cfg[15]), .el3_is_64_i(cfg[14]),
      .split_deactivation_bit_ctlr_i(cfg[13]), .split_deactivation_bit_el3_i(cfg[12]),
      .split_deactivation_bit_el1s_i(cfg[11]), .split_deactivation_bit_el1ns_i(cfg[10]),
      .el1_sysreg_enable_i(cfg[9]), .el2_sysreg_enable_i(cfg[8]), .el3_sysreg_enable_i(cfg[7]),
      .fast_irq_route_override_i(cfg[6]), .normal_irq_route_override_i(cfg[5]),
      .trap_general_bit_i(cfg[4]), .group_twelve_trap_bit_i(cfg[3]),
      .trap_all_group0_bit_i(cfg[2]), .trap_common_regs_bit_i(cfg[1]),
      .fast_interrupt_route_bit_i(cfg[0]), .resp_valid_o(rv), .resp_code_o(rc),
      .prio_drop_o(pd), .deactivate_o(da), .virt_write_o(vw), .interrupt_identifier_o(ident),
      .identifier_width_field_o(idw));
   task chk(input logic [23:0] seen, input logic [23:0] exp);
      begin
         samples_checked++;
         if (seen !== exp)
         begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // Mode is {target, level, secure, monitor}; e is {code, drop, deactivate}
   task t(input logic [17:0] c, input logic [4:0] m, input logic [31:0] w, input logic [6:0] e);
      begin
         cfg = c;
         i_core_write_model.write(m, w);
         chk(rv, 1'b1);
         chk(rc, e[6:2]);
         chk({pd, da}, e[1:0]);
         chk(vw, e[6:2] == `OUT_VIRTUAL);
      end
   endtask
   task end_of_test;
      begin
         if (error_cnt == 0 && samples_checked > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   initial
   begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   initial
   begin
      #20000;
      error_cnt++;
      end_of_test;
   end
   initial
   begin
      error_cnt = 0;
      samples_checked = 0;
      cfg = 18'h30380;
      ce = 1'b1;
      srst_i = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      srst_i = 1'b0;
      t(18'h30380, 5'h06, 32'hab000025, 7'h07);
      chk(ident, 24'h000025);
      chk(idw, `IDW_CODE_24);
      t(18'h32380, 5'h06, 32'h00000025, 7'h06);
      t(18'h32380, 5'h16, 32'h00000025, 7'h05);
      t(18'h31380, 5'h06, 32'h00000026, 7'h07);
      t(18'h30380, 5'h06, 32'h000003fe, 7'h04);
      t(18'h30380, 5'h06, 32'hff0003ff, 7'h04);
      t(18'h30380, 5'h06, 32'h000003fb, 7'h07);
      t(18'h3d380, 5'h0f, 32'h00000027, 7'h06);
      t(18'h3d380, 5'h06, 32'h00000028, 7'h07);
      t(18'h3c780, 5'h04, 32'h00000029, 7'h06);
      t(18'h30180, 5'h06, 32'h0000002a, 7'h08);
      t(18'h30280, 5'h08, 32'h0000002a, 7'h08);
      t(18'h303c0, 5'h04, 32'h0000002b, 7'h40);
      t(18'h303a0, 5'h14, 32'h0000002b, 7'h40);
      t(18'h30390, 5'h04, 32'h0000002c, 7'h08);
      t(18'h30388, 5'h04, 32'h0000002d, 7'h10);
      t(18'h30384, 5'h04, 32'h0000002d, 7'h10);
      t(18'h30382, 5'h14, 32'h0000002e, 7'h10);
      t(18'h30382, 5'h04, 32'h0000002e, 7'h07);
      t(18'h38381, 5'h08, 32'h0000002f, 7'h08);
      t(18'h38381, 5'h04, 32'h0000002f, 7'h08);
      t(18'h383c1, 5'h04, 32'h0000002f, 7'h40);
      t(18'h3c381, 5'h06, 32'h00000030, 7'h20);
      t(18'h3c381, 5'h08, 32'h00000030, 7'h20);
      t(18'h3c381, 5'h04, 32'h00000030, 7'h20);
      t(18'h2c381, 5'h04, 32'h00000030, 7'h20);
      t(18'h303a0, 5'h04, 32'h00000033, 7'h07);
      t(18'h10388, 5'h04, 32'h00000034, 7'h07);
      // Enable low holds the last pulses and refuses a new write
      t(18'h30380, 5'h06, 32'h00000031, 7'h07);
      ce = 1'b0;
      @(negedge sys_clk_i);
      chk({rv, pd, da}, 3'h7);
      i_core_write_model.write(5'h04, 32'h00000032);
      chk({rv, pd, da}, 3'h7);
      chk(ident, 24'h000031);
      ce = 1'b1;
      @(negedge sys_clk_i);
      chk({rv, pd, da}, 3'h0);
      end_of_test;
   end
endmodule
